// *** rtl/tsf_device.sv ***
/*
 Device end of the temperature sample store: 32 x 16-bit sample memory,
 pointers, counters, configuration registers and register access slave.
 Assumes pushes come from a conversion engine on the same clock and that
 register requests arrive on the interface one at a time.
*/
`timescale 1ns/1ps
module tsf_device #(
	parameter int DEPTH = tsf_pkg::TSF_DEPTH,
	parameter int WORD_W = tsf_pkg::TSF_WORD_W
) (
	input wire logic clk_i,                    // 40 MHz clock
	input wire logic resetn_i,                 // Synchronous reset, active low
	tsf_if.device bus,                         // Register access channel
	input wire logic push_i,                   // Conversion done, one-cycle pulse
	input wire logic [WORD_W-1:0] sample_i,    // Sample pushed with push_i
	input wire logic status_read_i,            // Status register read, clears flag
	output logic almost_full_o                 // Almost-full status flag
);
	import tsf_pkg::*;

	// ==========================================================
	// State
	logic [WORD_W-1:0] mem_r [DEPTH];
	logic [4:0] push_ptr_r;
	logic [4:0] pop_ptr_r;
	logic [4:0] lost_r;
	logic [5:0] count_r;
	logic [4:0] wmark_r;
	logic rollover_r;
	logic afull_type_r;
	logic stat_clr_r;
	logic byte_sel_r;
	logic [7:0] rdata_r;
	logic ack_r;
	logic afull_r;
	logic afull_cond_d_r;
	logic push_d_r;

	// ==========================================================
	// Decode of requests and events
	logic rd_req;
	logic wr_req;
	logic data_rd;
	logic pop_word;
	logic flush;
	logic full;
	logic store;
	logic ovwr;
	logic ptr_wr;
	logic afull_cond;
	logic [5:0] afull_level;
	logic [7:0] data_byte;

	assign rd_req = bus.req && !bus.wr;
	assign wr_req = bus.req && bus.wr;
	assign data_rd = rd_req && (bus.addr == TSF_OFS_DATA);
	// Second byte of a burst completes a word; a lone first byte pops nothing
	assign pop_word = data_rd && byte_sel_r && (count_r != 6'h00);
	assign flush = wr_req && (bus.addr == TSF_OFS_CTRL) && bus.wdata[TSF_BIT_FLUSH];
	assign ptr_wr = wr_req && (bus.addr == TSF_OFS_POP_PTR);
	assign full = (count_r == TSF_FULL_COUNT);
	assign store = push_i && (!full || rollover_r);
	assign ovwr = push_i && full && rollover_r && !pop_word;
	assign afull_level = TSF_FULL_COUNT - {1'b0, wmark_r};
	assign afull_cond = (count_r >= afull_level);
	// Empty store reads zero, not a stale entry; a reread needs a nonzero count
	assign data_byte = (count_r == 6'h00) ? 8'h00 : (byte_sel_r ? mem_r[pop_ptr_r][7:0] : mem_r[pop_ptr_r][15:8]);

	// Sample memory, straight bit mapping of the temperature word
	always_ff @(posedge clk_i)
	begin
		if (store)
			mem_r[push_ptr_r] <= sample_i;
	end

	// Push pointer: free 5-bit wrap
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || flush)
			push_ptr_r <= 5'h00;
		else if (store)
			push_ptr_r <= push_ptr_r + 5'h01;
	end

	// Pop pointer: advances on word pop or when rollover overwrites the oldest
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || flush)
			pop_ptr_r <= 5'h00;
		else if (ptr_wr)
			pop_ptr_r <= bus.wdata[4:0];
		else if (pop_word || ovwr)
			pop_ptr_r <= pop_ptr_r + 5'h01;
	end

	// Available word count; a rewritten pop pointer does not change it
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || flush)
			count_r <= 6'h00;
		else if (store && !full && !pop_word)
			count_r <= count_r + 6'h01;
		else if (pop_word && !store)
			count_r <= count_r - 6'h01;
	end

	// Lost word counter: a pop clears it, but a sample discarded in that cycle still counts
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || flush)
			lost_r <= 5'h00;
		else if (pop_word)
			lost_r <= (push_i && !store) ? 5'h01 : 5'h00;
		else if (push_i && full && lost_r != TSF_LOST_MAX)
			lost_r <= lost_r + 5'h01;
	end

	// Configuration registers; flush bit is never stored so it reads back zero
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			wmark_r <= TSF_WMARK_RST;
			{stat_clr_r, afull_type_r, rollover_r} <= TSF_CTRL_RST;
		end
		else if (wr_req && bus.addr == TSF_OFS_WMARK)
			wmark_r <= bus.wdata[4:0];
		else if (wr_req && bus.addr == TSF_OFS_CTRL)
		begin
			rollover_r <= bus.wdata[TSF_BIT_ROLLOVER];
			afull_type_r <= bus.wdata[TSF_BIT_AFULL_TYPE];
			stat_clr_r <= bus.wdata[TSF_BIT_STAT_CLR];
		end
	end

	// Burst byte phase: any non-data access restarts the pair
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || flush)
			byte_sel_r <= 1'b0;
		else if (data_rd)
			byte_sel_r <= bus.burst_end ? 1'b0 : !byte_sel_r;
		else if (bus.req)
			byte_sel_r <= 1'b0;
	end

	// Almost-full flag, judged the cycle after a push so the count already holds the new word;
	// type 0 re-raises on every push, type 1 only on new entry
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || flush)
		begin
			afull_r <= 1'b0;
			afull_cond_d_r <= 1'b0;
			push_d_r <= 1'b0;
		end
		else
		begin
			afull_cond_d_r <= afull_cond;
			push_d_r <= push_i;
			if (afull_cond && (afull_type_r ? !afull_cond_d_r : push_d_r))
				afull_r <= 1'b1;
			else if (status_read_i || (stat_clr_r && data_rd))
				afull_r <= 1'b0;
		end
	end

	assign almost_full_o = afull_r;

	// Read mux and answer, one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			rdata_r <= 8'h00;
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= bus.req;
			if (rd_req)
			begin
				case (bus.addr)
					TSF_OFS_PUSH_PTR: rdata_r <= {3'h0, push_ptr_r};
					TSF_OFS_POP_PTR: rdata_r <= {3'h0, pop_ptr_r};
					TSF_OFS_LOST: rdata_r <= {3'h0, lost_r};
					TSF_OFS_AVAIL: rdata_r <= {2'h0, count_r};
					TSF_OFS_DATA: rdata_r <= data_byte;
					TSF_OFS_WMARK: rdata_r <= {3'h0, wmark_r};
					TSF_OFS_CTRL: rdata_r <= {3'h0, 1'b0, stat_clr_r, afull_type_r, rollover_r, 1'b0};
					default: rdata_r <= 8'h00;
				endcase
			end
		end
	end

	assign bus.rdata = rdata_r;
	assign bus.ack = ack_r;
endmodule

// *** rtl/tsf_if.sv ***
/*
 Interface joining the sample store device and its master: a simple
 byte-wide register access channel standing in for the serial framing.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface tsf_if;
	logic req;       // Master request, one-cycle pulse
	logic wr;        // 1 write, 0 read
	logic [7:0] addr; // Register offset
	logic [7:0] wdata; // Write data
	logic burst_end; // Marks last byte of a burst
	logic [7:0] rdata; // Read data from device
	logic ack;       // Device answer, one-cycle pulse
	modport device (input req, input wr, input addr, input wdata, input burst_end, output rdata, output ack);
	modport master (output req, output wr, output addr, output wdata, output burst_end, input rdata, input ack);
endinterface

// *** rtl/tsf_master.sv ***
/*
 Master end of the sample store: reads the lost counter, then drains N
 samples with two-byte bursts; also forwards single register commands.
 Assumes the device answers each request with ack one cycle later.
*/
`timescale 1ns/1ps
module tsf_master (
	input wire logic clk_i,            // 40 MHz clock
	input wire logic resetn_i,         // Synchronous reset, active low
	tsf_if.master bus,                 // Register access channel
	input wire logic cmd_valid_i,      // Single register access, pulse
	input wire logic cmd_wr_i,         // 1 write, 0 read
	input wire logic [7:0] cmd_addr_i, // Register offset
	input wire logic [7:0] cmd_wdata_i, // Write data
	input wire logic drain_i,          // Start draining, pulse
	input wire logic [5:0] drain_n_i,  // Samples to drain
	output logic busy_o,               // Access in progress
	output logic [7:0] cmd_rdata_o,    // Last single read data
	output logic [4:0] lost_o,         // Lost counter seen before draining
	output logic sample_valid_o,       // Sample word ready, pulse
	output logic [15:0] sample_o       // Drained sample word
);
	import tsf_pkg::*;

	typedef enum logic [2:0] {
		TSF_IDLE = 3'b000,
		TSF_CMD = 3'b001,
		TSF_LOST = 3'b010,
		TSF_HI = 3'b011,
		TSF_LO = 3'b100
	} tsf_state_e;

	// ==========================================================
	// State
	tsf_state_e state_r;
	logic [5:0] left_r;
	logic req_r;
	logic wr_r;
	logic [7:0] addr_r;
	logic [7:0] wdata_r;
	logic end_r;
	logic [7:0] hi_r;

	// Sequencer: one request outstanding, next one issued on ack
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			state_r <= TSF_IDLE;
			left_r <= 6'h00;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			wdata_r <= 8'h00;
			end_r <= 1'b0;
			hi_r <= 8'h00;
			cmd_rdata_o <= 8'h00;
			lost_o <= 5'h00;
			sample_valid_o <= 1'b0;
			sample_o <= 16'h0000;
		end
		else
		begin
			req_r <= 1'b0;
			sample_valid_o <= 1'b0;
			case (state_r)
				TSF_IDLE:
				begin
					if (drain_i && drain_n_i != 6'h00)
					begin
						// Lost counter read first so an overflow is caught before draining
						state_r <= TSF_LOST;
						left_r <= drain_n_i;
						req_r <= 1'b1;
						wr_r <= 1'b0;
						addr_r <= TSF_OFS_LOST;
						end_r <= 1'b0;
					end
					else if (cmd_valid_i)
					begin
						state_r <= TSF_CMD;
						req_r <= 1'b1;
						wr_r <= cmd_wr_i;
						addr_r <= cmd_addr_i;
						wdata_r <= cmd_wdata_i;
						end_r <= 1'b1;
					end
				end
				TSF_CMD:
					if (bus.ack)
					begin
						cmd_rdata_o <= bus.rdata;
						state_r <= TSF_IDLE;
					end
				TSF_LOST:
					if (bus.ack)
					begin
						lost_o <= bus.rdata[4:0];
						state_r <= TSF_HI;
						req_r <= 1'b1;
						addr_r <= TSF_OFS_DATA;
						end_r <= 1'b0;
					end
				TSF_HI:
					if (bus.ack)
					begin
						hi_r <= bus.rdata;
						state_r <= TSF_LO;
						req_r <= 1'b1;
						end_r <= 1'b1;
					end
				TSF_LO:
					if (bus.ack)
					begin
						sample_o <= {hi_r, bus.rdata};
						sample_valid_o <= 1'b1;
						left_r <= left_r - 6'h01;
						if (left_r == 6'h01)
							state_r <= TSF_IDLE;
						else
						begin
							state_r <= TSF_HI;
							req_r <= 1'b1;
							end_r <= 1'b0;
						end
					end
				default: state_r <= TSF_IDLE;
			endcase
		end
	end

	assign busy_o = (state_r != TSF_IDLE);
	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign bus.burst_end = end_r;
endmodule

// *** rtl/tsf_pkg.sv ***
/*
 Package for the temperature sample store: register offsets, field layouts,
 reset values and sizes shared by the device end and the master end.
 Assumes 8-bit register addresses and 8-bit register data.
*/
package tsf_pkg;
	// ==========================================================
	// Sizes
	localparam int TSF_DEPTH = 32;
	localparam int TSF_WORD_W = 16;
	localparam int TSF_PTR_W = 5;
	localparam int TSF_CNT_W = 6;
	localparam logic [5:0] TSF_FULL_COUNT = 6'h20;
	localparam logic [4:0] TSF_LOST_MAX = 5'h1F;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] TSF_OFS_PUSH_PTR = 8'h04;
	localparam logic [7:0] TSF_OFS_POP_PTR = 8'h05;
	localparam logic [7:0] TSF_OFS_LOST = 8'h06;
	localparam logic [7:0] TSF_OFS_AVAIL = 8'h07;
	localparam logic [7:0] TSF_OFS_DATA = 8'h08;
	localparam logic [7:0] TSF_OFS_WMARK = 8'h09;
	localparam logic [7:0] TSF_OFS_CTRL = 8'h0A;
	// ==========================================================
	// Control register field positions
	localparam int TSF_BIT_ROLLOVER = 1;
	localparam int TSF_BIT_AFULL_TYPE = 2;
	localparam int TSF_BIT_STAT_CLR = 3;
	localparam int TSF_BIT_FLUSH = 4;
	// ==========================================================
	// Reset values
	localparam logic [4:0] TSF_WMARK_RST = 5'h00;
	localparam logic [2:0] TSF_CTRL_RST = 3'h0;
endpackage

// *** sim/temp_sample_fifo_tb.sv ***
/*
 Bench: device and master joined by the channel, driven at master side, with pushes and status reads driven at the device.
 Assumes the master drops busy_o when an access or drain is over.
*/
`timescale 1ns/1ps
module temp_sample_fifo_tb;
	import tsf_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic push_i = 1'b0;
	logic [15:0] sample_i = 16'h0000;
	logic status_read_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic cmd_wr_i = 1'b0;
	logic [7:0] cmd_addr_i = 8'h00;
	logic [7:0] cmd_wdata_i = 8'h00;
	logic drain_i = 1'b0;
	logic [5:0] drain_n_i = 6'h00;
	logic busy_o, almost_full_o, sample_valid_o;
	logic [7:0] cmd_rdata_o;
	logic [4:0] lost_o;
	logic [15:0] sample_o, want;
	logic [15:0] seq = 16'h5A00;
	int fail_count = 0;
	int n_checks = 0;
	int got = 0;
	int cyc = 0;
	tsf_if i_tsf_if ();
	tsf_device i_tsf_device (.clk_i(clk_i), .resetn_i(resetn_i), .bus(i_tsf_if), .push_i(push_i),
		.sample_i(sample_i), .status_read_i(status_read_i), .almost_full_o(almost_full_o));
	tsf_master i_tsf_master (.clk_i(clk_i), .resetn_i(resetn_i), .bus(i_tsf_if), .cmd_valid_i(cmd_valid_i),
		.cmd_wr_i(cmd_wr_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .drain_i(drain_i),
		.drain_n_i(drain_n_i), .busy_o(busy_o), .cmd_rdata_o(cmd_rdata_o), .lost_o(lost_o),
		.sample_valid_o(sample_valid_o), .sample_o(sample_o));
	tsf_assertions i_tsf_assertions (.clk_i(clk_i), .resetn_i(resetn_i), .req(i_tsf_if.req),
		.wr(i_tsf_if.wr), .addr(i_tsf_if.addr), .wdata(i_tsf_if.wdata), .burst_end(i_tsf_if.burst_end),
		.rdata(i_tsf_if.rdata), .ack(i_tsf_if.ack));
	// ==========================================================
	// Clock and hang guard; no run should come near the ceiling
	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			fail_count++;
			summarize();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Drop the strobes, then wait for idle; one extra cycle catches a late word
	task automatic go;
		int k;
		bit idle;
		idle = 0;
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		drain_i <= 1'b0;
		#1;
		for (k = 0; k < 400; k++)
		begin
			if (sample_valid_o === 1'b1)
			begin
				chk("sample", want, sample_o);
				want++;
				got++;
			end
			if (idle)
				break;
			idle = (busy_o === 1'b0);
			@(posedge clk_i);
			#1;
		end
		// A master that never goes idle is a mismatch, not a silent pass
		chk("idle", 16'h0001, {15'h0000, idle});
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cmd_valid_i <= 1'b1;
		cmd_wr_i <= w;
		cmd_addr_i <= a;
		cmd_wdata_i <= d;
		go();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, cmd_rdata_o});
	endtask
	task automatic drain(input logic [5:0] n, input logic [4:0] lost, input logic [15:0] first);
		got = 0;
		want = first;
		@(posedge clk_i);
		drain_i <= 1'b1;
		drain_n_i <= n;
		go();
		chk("words", {10'h000, n}, got[15:0]);
		chk("lost", {11'h000, lost}, {11'h000, lost_o});
	endtask
	task automatic push(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			push_i <= 1'b1;
			sample_i <= seq;
			seq++;
			@(posedge clk_i);
			push_i <= 1'b0;
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		for (int a = 4; a < 11; a++)
			rd(a[7:0], 8'h00);
		acc(1'b1, TSF_OFS_PUSH_PTR, 8'h1F);
		rd(TSF_OFS_PUSH_PTR, 8'h00);
		rd(8'h0B, 8'h00);
	endtask
	task automatic t_basic;
		push(3);
		rd(TSF_OFS_AVAIL, 8'h03);
		rd(TSF_OFS_PUSH_PTR, 8'h03);
		drain(6'h03, 5'h00, 16'h5A00);
		rd(TSF_OFS_POP_PTR, 8'h03);
		rd(TSF_OFS_AVAIL, 8'h00);
	endtask
	task automatic t_reread;
		push(1);
		acc(1'b1, TSF_OFS_POP_PTR, 8'h02);
		rd(TSF_OFS_AVAIL, 8'h01);
		drain(6'h01, 5'h00, 16'h5A02);
	endtask
	task automatic t_full;
		acc(1'b1, TSF_OFS_CTRL, 8'h10);
		for (int a = 4; a < 11; a++)
			rd(a[7:0], 8'h00);
		push(32);
		rd(TSF_OFS_AVAIL, 8'h20);
		rd(TSF_OFS_PUSH_PTR, 8'h00);
		push(2);
		rd(TSF_OFS_LOST, 8'h02);
		drain(6'h01, 5'h02, 16'h5A04);
		rd(TSF_OFS_LOST, 8'h00);
		acc(1'b1, TSF_OFS_CTRL, 8'h02);
		push(2);
		rd(TSF_OFS_POP_PTR, 8'h02);
		drain(6'h01, 5'h01, 16'h5A06);
		drain(6'h1D, 5'h00, 16'h5A07);
		rd(TSF_OFS_POP_PTR, 8'h00);
		acc(1'b1, TSF_OFS_CTRL, 8'h00);
		push(62);
		rd(TSF_OFS_LOST, 8'h1F);
	endtask
	task automatic t_afull;
		acc(1'b1, TSF_OFS_WMARK, 8'h02);
		acc(1'b1, TSF_OFS_CTRL, 8'h10);
		rd(TSF_OFS_WMARK, 8'h02);
		push(29);
		repeat (3) @(posedge clk_i);
		#1;
		chk("afull", 16'h0000, {15'h0000, almost_full_o});
		push(1);
		repeat (3) @(posedge clk_i);
		#1;
		chk("afull", 16'h0001, {15'h0000, almost_full_o});
		@(posedge clk_i);
		status_read_i <= 1'b1;
		@(posedge clk_i);
		status_read_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("afull", 16'h0000, {15'h0000, almost_full_o});
		// Status clear by data read; type 0 raises again on the next push
		acc(1'b1, TSF_OFS_CTRL, 8'h08);
		push(1);
		repeat (3) @(posedge clk_i);
		#1;
		chk("afull", 16'h0001, {15'h0000, almost_full_o});
		drain(6'h01, 5'h00, 16'h5A66);
		chk("afull", 16'h0000, {15'h0000, almost_full_o});
		// Type 1 stays low while the level holds, then raises on a new crossing
		acc(1'b1, TSF_OFS_CTRL, 8'h04);
		push(1);
		repeat (3) @(posedge clk_i);
		#1;
		chk("afull", 16'h0000, {15'h0000, almost_full_o});
		drain(6'h02, 5'h00, 16'h5A67);
		push(1);
		repeat (3) @(posedge clk_i);
		#1;
		chk("afull", 16'h0001, {15'h0000, almost_full_o});
	endtask
	// Reset in mid-run with words stored and the flag up
	task automatic t_midreset;
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		#1;
		chk("afull", 16'h0000, {15'h0000, almost_full_o});
		rd(TSF_OFS_AVAIL, 8'h00);
		rd(TSF_OFS_POP_PTR, 8'h00);
		rd(TSF_OFS_PUSH_PTR, 8'h00);
		rd(TSF_OFS_WMARK, 8'h00);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_basic();
		t_reread();
		t_full();
		t_afull();
		t_midreset();
		summarize();
	end
endmodule

// *** sim/tsf_assertions.sv ***
/*
 Checker for the sample store register channel.
 Assumes the channel signals are wired in by name beside the interface.
*/
`timescale 1ns/1ps
module tsf_assertions (
	input wire logic clk_i, // Clock
	input wire logic resetn_i, // Reset, low
	input wire logic req, // Request
	input wire logic wr, // Write
	input wire logic [7:0] addr, // Offset
	input wire logic [7:0] wdata, // Write data
	input wire logic burst_end, // Last byte
	input wire logic [7:0] rdata, // Read data
	input wire logic ack // Answer
);
	import tsf_pkg::*;
	logic [4:0] wm_r;
	logic [2:0] ct_r;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// ==========================================================
	// Shadows of the config writes; only the channel writes them
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			wm_r <= 5'h00;
			ct_r <= 3'h0;
		end
		else if (req && wr && addr == TSF_OFS_WMARK)
			wm_r <= wdata[4:0];
		else if (req && wr && addr == TSF_OFS_CTRL)
			ct_r <= wdata[3:1];
	end
	// ==========================================================
	// Properties
	sequence s_rd(logic [7:0] a);
		req && !wr && addr == a;
	endsequence
	sequence s_pop;
		s_rd(TSF_OFS_DATA) ##0 burst_end;
	endsequence
	property p_ack;
		req |=> ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_src;
		ack |-> $past(req);
	endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	property p_wptr;
		s_rd(TSF_OFS_PUSH_PTR) |=> rdata[7:5] == 3'h0;
	endproperty
	a_wptr: assert property (p_wptr) else $error("push pointer too wide");
	property p_rptr;
		s_rd(TSF_OFS_POP_PTR) |=> rdata[7:5] == 3'h0;
	endproperty
	a_rptr: assert property (p_rptr) else $error("pop pointer too wide");
	property p_lost;
		s_rd(TSF_OFS_LOST) |=> rdata[7:5] == 3'h0;
	endproperty
	a_lost: assert property (p_lost) else $error("lost counter too wide");
	property p_count;
		s_rd(TSF_OFS_AVAIL) |=> rdata <= 8'h20;
	endproperty
	a_count: assert property (p_count) else $error("word count above depth");
	property p_lost_clr;
		s_pop ##[1:8] s_rd(TSF_OFS_LOST) |=> rdata == 8'h00;
	endproperty
	a_lost_clr: assert property (p_lost_clr) else $error("lost counter kept after pop");
	property p_wmark;
		s_rd(TSF_OFS_WMARK) |=> rdata == {3'h0, wm_r};
	endproperty
	a_wmark: assert property (p_wmark) else $error("watermark readback");
	property p_ctrl;
		s_rd(TSF_OFS_CTRL) |=> rdata == {4'h0, ct_r, 1'b0};
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control readback");
	property p_unmap;
		req && !wr && (addr < 8'h04 || addr > 8'h0A) |=> rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
